// >>> hdl/mrec_controller.sv
// Memory array controller with error correction, staged recovery mode, scrubbing and spare bit
//
// Behaviour
// - Every stored word carries a code correcting one-bit and detecting two-bit errors.
// - Normally read data goes out before the code check finishes.
// - While the permanent error window is open, reads use staged mode.
// - Staged reads return data only after correcting any correctable error.
// - Staged reads raise no error report for corrected errors.
// - Retries hitting a permanent one-bit fault get corrected data, no report.
// - Each refresh also reads one array location and checks its code.
// - Scrub errors are reported; correctable ones are written back corrected.
// - Scrubbing steps through the array so each word is checked about once a second.
// - The spare column can replace any one bit of the 39-bit word.
// - The spare bit is used only when software commands it, never by hardware.
// - The timeout duration sets both quiet period and permanent error window.
// - At minimum timeout duration, permanent error recovery takes about 32 us.
// - At minimum timeout duration, faults lasting over 16 us count as permanent.
// - Larger timeout duration lengthens recovery and masks longer transients proportionally.
// - Recovery retries first; reconfiguration follows only if the retry fails too.
// - Reconfiguration happens in the first cycles of the quiet period.
`timescale 1ns/100ps
module mrec_controller import mrec_pkg::*; #(
    parameter int unsigned REFRESH_CYCLES = REFRESH_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Access requests from the memory bus side
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [ADDR_W-1:0] reqAddr,
    input wire logic [DATA_W-1:0] reqWdata,
    output logic reqReady,
    // Read answers
    output logic rspValid,
    output logic [DATA_W-1:0] rspData,
    // Error reporting
    output logic errReport,
    output logic errUncorr,
    output logic errScrub,
    output logic [ADDR_W-1:0] errAddr,
    // Recovery control
    input wire logic busError,
    input wire logic [TDUR_W-1:0] timeoutDuration,
    output logic stagedMode,
    output logic permError,
    output logic reconfigure,
    // Software spare bit command
    input wire logic spareEnable,
    input wire logic [SPARE_SEL_W-1:0] spareSel
);

    mrec_state_type r;
    mrec_state_type n;

    // Array and its port
    logic [WORD_W-1:0] memArray [DEPTH];
    logic [WORD_W-1:0] memRd_r;
    logic [ADDR_W-1:0] rdAddr;
    logic wrEn;
    logic [ADDR_W-1:0] wrAddr;
    logic [WORD_W-1:0] wrWord;

    // Codec wiring
    logic [DATA_W-1:0] encData;
    logic [CODE_W-1:0] encCode;
    logic [CODE_W-1:0] decCode;
    logic [DATA_W-1:0] decRaw;
    logic [DATA_W-1:0] decFixed;
    logic decSingle;
    logic decDouble;

    // Recovery helpers
    logic [REC_CNT_W-1:0] phaseLen;
    logic recTrigger;
    logic spareValid;

    // Code generator and checker shared by accesses and scrubs
    mrec_ecc_codec u_codec (
        .encData(encData),
        .encCode(encCode),
        .decCode(decCode),
        .decRaw(decRaw),
        .decFixed(decFixed),
        .decSingle(decSingle),
        .decDouble(decDouble)
    );

    // Array: one synchronous read and one write port, contents not reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            memRd_r <= '0;
        end else begin
            memRd_r <= memArray[rdAddr];
        end
    end

    // Array write port
    always_ff @(posedge core_clk) begin
        if (wrEn) begin
            memArray[wrAddr] <= wrWord;
        end
    end

    // Spare mapping only under software command; a selector past the word does nothing
    always_comb begin
        spareValid = spareEnable && (int'(spareSel) < CODE_W);
        decCode = memRd_r[CODE_W-1:0];
        if (spareValid) begin
            decCode[spareSel] = memRd_r[SPARE_IDX];
        end
    end

    // Length of one recovery phase: one base unit per duration step
    always_comb begin
        phaseLen = REC_CNT_W'((int'(timeoutDuration) + 1) * WIN_BASE_CYC);
    end

    // Errors that start a recovery: bus errors and reported access errors, not scrub errors
    always_comb begin
        recTrigger = busError || (r.errReport && !r.errScrub);
    end

    // Next-state logic for the whole controller
    always_comb begin
        n = r;
        rdAddr = r.addr;
        wrEn = 1'b0;
        wrAddr = r.addr;
        wrWord = '0;
        encData = reqWdata;

        // Pulses last one cycle
        n.rspValid = 1'b0;
        n.errReport = 1'b0;
        n.permError = 1'b0;
        n.reconfigure = 1'b0;

        // Access sequencer
        unique case (r.acc)
            S_IDLE: begin
                if (reqValid && r.reqReady) begin
                    n.addr = reqAddr;
                    rdAddr = reqAddr;
                    n.isScrub = 1'b0;
                    n.staged = (r.rec == R_WINDOW);
                    if (reqWrite) begin
                        // Store with code; spare column shadows the selected bit, or code bit 0 while the spare is disabled
                        wrEn = 1'b1;
                        wrAddr = reqAddr;
                        wrWord = {encCode[spareValid ? spareSel : '0], encCode};
                    end else begin
                        n.acc = S_FETCH;
                    end
                end else if (r.refPend) begin
                    // Refresh access doubles as a real read of the scrub location
                    n.refPend = 1'b0;
                    n.addr = r.scrubPtr;
                    rdAddr = r.scrubPtr;
                    n.isScrub = 1'b1;
                    n.staged = 1'b0;
                    n.acc = S_FETCH;
                    if (int'(r.scrubPtr) == DEPTH - 1) begin
                        n.scrubPtr = '0;
                    end else begin
                        n.scrubPtr = r.scrubPtr + ADDR_W'(1);
                    end
                end
            end
            S_FETCH: begin
                // Check runs on the word just read
                n.corrData = decFixed;
                n.single = decSingle;
                n.double = decDouble;
                if (!r.isScrub && !r.staged) begin
                    n.rspValid = 1'b1;
                    n.rspData = decRaw;
                end
                n.acc = S_CHECK;
            end
            S_CHECK: begin
                n.errAddr = r.addr;
                n.errScrub = r.isScrub;
                n.errUncorr = r.double;
                if (r.isScrub) begin
                    n.errReport = r.single || r.double;
                    if (r.single) begin
                        // Correctable scrub error: put the repaired word back
                        encData = r.corrData;
                        wrEn = 1'b1;
                        wrWord = {encCode[spareValid ? spareSel : '0], encCode};
                    end
                    // An uncorrectable word keeps its stored contents
                end else if (r.staged) begin
                    n.rspValid = 1'b1;
                    n.rspData = r.corrData;
                    n.errReport = r.double;
                end else begin
                    n.errReport = r.single || r.double;
                end
                n.acc = S_IDLE;
            end
            default: begin
                n.acc = S_IDLE;
            end
        endcase

        // Refresh timer; a tick in the cycle a pending scrub is taken stays pending
        if (r.refCnt == '0) begin
            n.refCnt = REF_CNT_W'(REFRESH_CYCLES - 1);
            n.refPend = 1'b1;
        end else begin
            n.refCnt = r.refCnt - REF_CNT_W'(1);
        end

        // Recovery phases: quiet period, then window in which a repeated error is permanent
        unique case (r.rec)
            R_IDLE: begin
                if (recTrigger) begin
                    n.rec = R_QUIET;
                    n.recCnt = phaseLen - REC_CNT_W'(1);
                end
            end
            R_QUIET: begin
                // Errors while quiet are masked as transients
                if (r.recCnt == '0) begin
                    n.rec = R_WINDOW;
                    n.recCnt = phaseLen - REC_CNT_W'(1);
                end else begin
                    n.recCnt = r.recCnt - REC_CNT_W'(1);
                end
            end
            R_WINDOW: begin
                if (recTrigger) begin
                    // Retry failed: permanent error, reconfigure at the start of the next quiet
                    n.permError = 1'b1;
                    n.reconfigure = 1'b1;
                    n.rec = R_QUIET;
                    n.recCnt = phaseLen - REC_CNT_W'(1);
                end else if (r.recCnt == '0) begin
                    n.rec = R_IDLE;
                end else begin
                    n.recCnt = r.recCnt - REC_CNT_W'(1);
                end
            end
            default: begin
                n.rec = R_IDLE;
            end
        endcase

        // Mode and ready flags, registered for the ports
        n.stagedMode = (n.rec == R_WINDOW);
        n.reqReady = (n.acc == S_IDLE) && !n.refPend;
    end

    // State register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= MREC_RESET;
        end else begin
            r <= n;
        end
    end

    // Ports straight from the state register
    assign reqReady = r.reqReady;
    assign rspValid = r.rspValid;
    assign rspData = r.rspData;
    assign errReport = r.errReport;
    assign errUncorr = r.errUncorr;
    assign errScrub = r.errScrub;
    assign errAddr = r.errAddr;
    assign stagedMode = r.stagedMode;
    assign permError = r.permError;
    assign reconfigure = r.reconfigure;

endmodule // mrec_controller

// >>> shared/mrec_pkg.sv
// Shared constants and state types for the memory array error recovery block
package mrec_pkg;

    // Word geometry: 32 data bits, 6 Hamming checks and 1 overall parity, plus the spare column
    localparam int DATA_W = 32;
    localparam int CODE_W = 39;
    localparam int WORD_W = 40;
    localparam int SPARE_IDX = 39;
    localparam int HAM_TOP = 38;
    localparam int SYN_W = 6;
    localparam int SPARE_SEL_W = 6;

    // Array size
    localparam int ADDR_W = 8;
    localparam int DEPTH = 256;

    // Clock rate
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLK_HZ = 100_000_000;

    // Timeout duration: each step adds one base unit to the quiet period and to the window
    localparam int TDUR_W = 4;
    localparam int WIN_BASE_NS = 16_000;
    localparam int WIN_BASE_CYC = (WIN_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REC_CNT_W = 15;

    // Scrub sweep: the whole array is checked once per sweep time
    localparam int SWEEP_MS = 1000;
    localparam int REFRESH_CYC = CLK_HZ / 1000 * SWEEP_MS / DEPTH;
    localparam int REF_CNT_W = 20;

    // Access sequencer states
    typedef enum logic [2:0] {
        S_IDLE  = 3'h1,
        S_FETCH = 3'h2,
        S_CHECK = 3'h4
    } mrec_acc_type;

    // Recovery phases
    typedef enum logic [2:0] {
        R_IDLE   = 3'h1,
        R_QUIET  = 3'h2,
        R_WINDOW = 3'h4
    } mrec_rec_type;

    // Complete state of the controller
    typedef struct packed {
        mrec_acc_type acc;
        mrec_rec_type rec;
        logic isScrub;
        logic staged;
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] scrubPtr;
        logic [REF_CNT_W-1:0] refCnt;
        logic refPend;
        logic [DATA_W-1:0] corrData;
        logic single;
        logic double;
        logic [REC_CNT_W-1:0] recCnt;
        logic reqReady;
        logic rspValid;
        logic [DATA_W-1:0] rspData;
        logic errReport;
        logic errUncorr;
        logic errScrub;
        logic [ADDR_W-1:0] errAddr;
        logic stagedMode;
        logic permError;
        logic reconfigure;
    } mrec_state_type;

    // Reset value of the controller state
    localparam mrec_state_type MREC_RESET = '{
        acc: S_IDLE,
        rec: R_IDLE,
        default: '0
    };

endpackage

// >>> hdl/mrec_ecc_codec.sv
// Single-correct double-detect code over 32 data bits in a 39-bit word
`timescale 1ns/100ps
module mrec_ecc_codec import mrec_pkg::*; (
    // Encode side
    input wire logic [DATA_W-1:0] encData,
    output logic [CODE_W-1:0] encCode,
    // Decode side
    input wire logic [CODE_W-1:0] decCode,
    output logic [DATA_W-1:0] decRaw,
    output logic [DATA_W-1:0] decFixed,
    output logic decSingle,
    output logic decDouble
);

    // Encoder: data on non-power-of-two positions, checks on powers of two, bit 0 overall
    always_comb begin
        int k;
        logic par;
        k = 0;
        par = 1'b0;
        encCode = '0;
        for (int p = 1; p <= HAM_TOP; p++) begin
            if ((p & (p - 1)) != 0) begin
                encCode[p] = encData[k];
                k = k + 1;
            end
        end
        for (int i = 0; i < SYN_W; i++) begin
            par = 1'b0;
            for (int p = 1; p <= HAM_TOP; p++) begin
                if (((p >> i) & 1) == 1) begin
                    par = par ^ encCode[p];
                end
            end
            encCode[1 << i] = par;
        end
        encCode[0] = ^encCode[HAM_TOP:1];
    end

    // Decoder: syndrome names the failing position, overall parity splits one from two errors
    always_comb begin
        int k;
        logic [SYN_W-1:0] syn;
        logic overall;
        logic [CODE_W-1:0] fixed;
        k = 0;
        syn = '0;
        overall = ^decCode;
        for (int p = 1; p <= HAM_TOP; p++) begin
            if (decCode[p]) begin
                syn = syn ^ SYN_W'(p);
            end
        end
        fixed = decCode;
        decSingle = overall && (int'(syn) <= HAM_TOP);
        decDouble = (!overall && syn != '0) || (overall && (int'(syn) > HAM_TOP));
        if (decSingle) begin
            fixed[syn] = ~decCode[syn];
        end
        decRaw = '0;
        decFixed = '0;
        for (int p = 1; p <= HAM_TOP; p++) begin
            if ((p & (p - 1)) != 0) begin
                decRaw[k] = decCode[p];
                decFixed[k] = fixed[p];
                k = k + 1;
            end
        end
    end

endmodule // mrec_ecc_codec

// >>> bench/mrec_ctrl_assertions.sv
// Port-level property checks for the memory array controller
`timescale 1ns/100ps
module mrec_ctrl_assertions import mrec_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Access and answers
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic reqReady,
    input wire logic rspValid,
    input wire logic errReport,
    input wire logic errUncorr,
    input wire logic errScrub,
    // Recovery
    input wire logic [TDUR_W-1:0] timeoutDuration,
    input wire logic stagedMode,
    input wire logic permError,
    input wire logic reconfigure
);
    logic [15:0] winCnt_r;
    wire rdTaken = reqValid && reqReady && !reqWrite;
    wire wrTaken = reqValid && reqReady && reqWrite;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // Counts the cycles of the open staged window
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            winCnt_r <= '0;
        end else begin
            winCnt_r <= stagedMode ? winCnt_r + 16'h0001 : 16'h0000;
        end
    end

    a_fast_read_lat: assert property (rdTaken && !stagedMode |=> !rspValid ##1 rspValid)
        else $error("fast read answer not two edges after request");
    a_staged_read_lat: assert property (rdTaken && stagedMode |=> !rspValid[*2] ##1 rspValid)
        else $error("staged read answer not three edges after request");
    a_staged_no_report: assert property (rdTaken && stagedMode |-> ##3 !(errReport && !errUncorr && !errScrub)[*2])
        else $error("staged read reported a corrected error");
    a_write_silent: assert property (wrTaken |=> !rspValid[*3])
        else $error("write produced a read answer");
    a_read_busy: assert property (rdTaken |=> !reqReady[*2])
        else $error("request accepted while read in progress");
    a_perm_pairs: assert property (permError == reconfigure)
        else $error("reconfigure not paired with permanent error");
    a_perm_in_window: assert property (permError |-> $past(stagedMode) && !stagedMode)
        else $error("permanent error outside the window");
    a_window_len: assert property ($fell(stagedMode) && !permError |->
            winCnt_r == 16'(WIN_BASE_CYC * (timeoutDuration + 1)))
        else $error("staged window length wrong");

    // Main scenarios reached
    c_staged_read: cover property (rdTaken && stagedMode);
    c_perm: cover property (permError);
    c_scrub_report: cover property (errReport && errScrub);
endmodule // mrec_ctrl_assertions

// >>> bench/mrec_bus_unit_model.sv
// Bus interface unit model issuing accesses, bus faults and spare commands
`timescale 1ns/100ps
module mrec_bus_unit_model import mrec_pkg::*; (
    // Clock
    input wire logic core_clk,
    // Requests
    output logic reqValid,
    output logic reqWrite,
    output logic [ADDR_W-1:0] reqAddr,
    output logic [DATA_W-1:0] reqWdata,
    input wire logic reqReady,
    // Answers
    input wire logic rspValid,
    input wire logic [DATA_W-1:0] rspData,
    input wire logic errReport,
    // Fault and software commands
    output logic busError,
    output logic spareEnable,
    output logic [SPARE_SEL_W-1:0] spareSel
);
    // Idle values at time zero
    initial begin
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqAddr = '0;
        reqWdata = '0;
        busError = 1'b0;
        spareEnable = 1'b0;
        spareSel = 6'h05;
    end

    // One access; lat counts edges from taking edge until read data is visible
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d, output int lat, output logic [DATA_W-1:0] q,
            output logic err);
        int n;
        lat = 0;
        err = 1'b0;
        q = '0;
        @(negedge core_clk);
        reqValid = 1'b1;
        reqWrite = wr;
        reqAddr = a;
        reqWdata = d;
        for (n = 0; n < 400 && reqReady !== 1'b1; n++) @(negedge core_clk);
        @(posedge core_clk);
        @(negedge core_clk);
        // Released lines show a changed pattern, not the last value
        reqValid = 1'b0;
        reqAddr = ~reqAddr;
        reqWdata = ~reqWdata;
        if (!wr) begin
            for (n = 1; n <= 5; n++) begin
                if (rspValid === 1'b1) begin
                    lat = n;
                    q = rspData;
                end
                if (errReport === 1'b1) err = 1'b1;
                @(negedge core_clk);
            end
        end
    endtask

    // One-cycle fault seen on the bus
    task automatic bus_fault();
        @(negedge core_clk);
        busError = 1'b1;
        @(negedge core_clk);
        busError = 1'b0;
    endtask

    // Spare column is changed only by this software command
    task automatic spare_cmd(input logic en, input logic [SPARE_SEL_W-1:0] sel);
        @(negedge core_clk);
        spareEnable = en;
        spareSel = sel;
    endtask
endmodule // mrec_bus_unit_model

// >>> bench/test_memory_array_error_recovery.sv
// Self-checking bench for the memory array error recovery controller
`timescale 1ns/100ps
module test_memory_array_error_recovery import mrec_pkg::*;;
    logic core_clk, reset_n, reqValid, reqWrite, reqReady, rspValid, errReport, errUncorr;
    logic errScrub, busError, stagedMode, permError, reconfigure, spareEnable;
    logic [ADDR_W-1:0] reqAddr, errAddr, lastScrub, p;
    logic [DATA_W-1:0] reqWdata, rspData;
    logic [TDUR_W-1:0] timeoutDuration;
    logic [SPARE_SEL_W-1:0] spareSel;
    logic [ADDR_W-1:0] accErrAddr;
    logic [1:0] accErrFlags;
    int failures = 0;
    int checks_done = 0;
    int scrubCnt = 0;
    bit scrubOn = 1'b0;
    int n;

    mrec_controller #(.REFRESH_CYCLES(20)) DUT (.core_clk, .reset_n, .reqValid, .reqWrite,
        .reqAddr, .reqWdata, .reqReady, .rspValid, .rspData, .errReport, .errUncorr, .errScrub,
        .errAddr, .busError, .timeoutDuration, .stagedMode, .permError, .reconfigure,
        .spareEnable, .spareSel);
    mrec_bus_unit_model BU (.core_clk, .reqValid, .reqWrite, .reqAddr, .reqWdata, .reqReady,
        .rspValid, .rspData, .errReport, .busError, .spareEnable, .spareSel);

    // Compare and count
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Read one word and judge latency, data and error pulse
    task automatic rd(input logic [ADDR_W-1:0] a, input int expLat,
            input logic [DATA_W-1:0] expQ, input logic expErr);
        int lat;
        logic [DATA_W-1:0] q;
        logic err;
        BU.access(1'b0, a, '0, lat, q, err);
        check(32'(lat), 32'(expLat));
        check(q, expQ);
        check(32'(err), 32'(expErr));
    endtask

    task automatic report_and_stop();
        $display("Checks made %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Fill the array with data 1; while disabled the spare column shadows code bit 0
    task automatic test_init();
        int lat;
        logic [DATA_W-1:0] q;
        logic err;
        BU.spare_cmd(1'b0, 6'h05);
        for (int a = 0; a < DEPTH; a++) BU.access(1'b1, 8'(a), 32'h0000_0001, lat, q, err);
        rd(8'h10, 2, 32'h0000_0001, 1'b0);
        $display("test init done");
    endtask

    // Spare on the shadowed bit reads clean; a disabled spare on bit 5 has no effect
    task automatic test_spare_cmd();
        BU.spare_cmd(1'b1, 6'h00);
        rd(8'h11, 2, 32'h0000_0001, 1'b0);
        BU.spare_cmd(1'b0, 6'h05);
        rd(8'h12, 2, 32'h0000_0001, 1'b0);
        $display("test spare command done");
    endtask

    // Spare on bit 5 now sets data bit 1 in every word not yet scrubbed
    task automatic test_fast_error();
        scrubOn = 1'b1;
        BU.spare_cmd(1'b1, 6'h05);
        for (n = 0; n < 100 && scrubCnt == 0; n++) @(negedge core_clk);
        p = lastScrub;
        rd(p, 2, 32'h0000_0001, 1'b0);
        rd(p - 8'h01, 2, 32'h0000_0003, 1'b1);
        check(32'(accErrAddr), 32'(ADDR_W'(p - 8'h01)));
        check(32'(accErrFlags), 32'h0000_0000);
        $display("test fast error done");
    endtask

    // Retry in the window returns corrected data without a report
    task automatic test_staged();
        for (n = 0; n < 2000 && stagedMode !== 1'b1; n++) @(negedge core_clk);
        check(32'(stagedMode), 32'h0000_0001);
        rd(p - 8'h02, 3, 32'h0000_0001, 1'b0);
        $display("test staged done");
    endtask

    // Fault in the window is permanent; phases follow the longer duration
    task automatic test_perm();
        timeoutDuration = 4'h1;
        BU.bus_fault();
        check(32'({permError, reconfigure, stagedMode}), 32'h0000_0006);
        for (n = 1; n < 10000 && stagedMode !== 1'b1; n++) @(negedge core_clk);
        check(32'(n), 32'(2 * WIN_BASE_CYC + 1));
        for (n = 0; n < 10000 && stagedMode === 1'b1; n++) @(negedge core_clk);
        check(32'(n), 32'(2 * WIN_BASE_CYC));
        $display("test permanent done");
    endtask

    // One full sweep reports every word exactly once and repairs it
    task automatic test_sweep();
        for (n = 0; n < 12000 && scrubCnt < DEPTH; n++) @(negedge core_clk);
        repeat (100) @(negedge core_clk);
        check(32'(scrubCnt), 32'(DEPTH));
        rd(p - 8'h01, 2, 32'h0000_0001, 1'b0);
        $display("test sweep done");
    endtask

    // Scrub reports must visit consecutive words, wrapping at the top
    always @(negedge core_clk) begin
        if (scrubOn && reset_n && errReport === 1'b1 && errScrub === 1'b1) begin
            if (scrubCnt > 0) check(32'(errAddr), 32'(ADDR_W'(lastScrub + 8'h01)));
            check(32'(errUncorr), 32'h0000_0000);
            lastScrub = errAddr;
            scrubCnt++;
        end else if (reset_n && errReport === 1'b1) begin
            // Keep the last access report while it stands, before a scrub overwrites it
            accErrAddr = errAddr;
            accErrFlags = {errUncorr, errScrub};
        end
    end

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Watchdog well beyond the expected run
    initial begin
        repeat (60000) @(posedge core_clk);
        failures++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        reset_n = 1'b0;
        timeoutDuration = 4'h0;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        reset_n = 1'b1;
        test_init();
        test_spare_cmd();
        test_fast_error();
        test_staged();
        test_perm();
        test_sweep();
        report_and_stop();
    end
endmodule // test_memory_array_error_recovery

bind mrec_controller mrec_ctrl_assertions CHK (.core_clk, .reset_n, .reqValid, .reqWrite,
    .reqReady, .rspValid, .errReport, .errUncorr, .errScrub, .timeoutDuration, .stagedMode,
    .permError, .reconfigure);
